//--- rtl/parallel_io_port_group.sv
// nine-port parallel i/o group with ahb-lite register access
//
// The AHB-Lite slave port was left to the implementer.
`default_nettype none
module parallel_io_port_group #(
  parameter int STATE_CYC = gpio_pkg::STATE_TIME_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [gpio_pkg::AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pads
  input wire gpio_pkg::port_vec_t pin_i,
  output gpio_pkg::pad_ctrl_t pad_o,
  output gpio_pkg::level_sel_t level_o
);
  import gpio_pkg::*;

  localparam int CW = (STATE_CYC > 1) ? $clog2(STATE_CYC) : 1;

  generate
    if (STATE_CYC < 1) begin : g_bad
      $error("STATE_CYC must be at least 1");
    end
    if (NPORT > 16) begin : g_bad_ports
      $error("port field holds at most 16 ports");
    end
    if (PW != 16) begin : g_bad_width
      $error("byte-half lanes need 16-bit ports");
    end
    if (AW != IDXW + 2) begin : g_bad_addr
      $error("byte address must be word index plus two bits");
    end
  endgenerate

  function automatic dec_t decode(input logic [IDXW-1:0] idx);
    dec_t d;
    d = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (idx == DAT_BASE + STRIDE * p[IDXW-1:0]) begin
        d = '{1'b1, p[3:0], K_DAT, LANE_W};
      end
      if (OUT_MASK[p] != '0 &&
          idx == SET_BASE + STRIDE * p[IDXW-1:0]) begin
        d = '{1'b1, p[3:0], K_SET, LANE_W};
      end
      if (OUT_MASK[p] != '0 &&
          idx == CLR_BASE + STRIDE * p[IDXW-1:0]) begin
        d = '{1'b1, p[3:0], K_CLR, LANE_W};
      end
      if (p >= 2 && OUT_MASK[p] != '0 && idx == DIR_IDX[p]) begin
        d = '{1'b1, p[3:0], K_DIR, LANE_W};
      end
      if (ODT_MASK[p] != '0 && idx == ODT_IDX[p]) begin
        d = '{1'b1, p[3:0], K_ODT, LANE_W};
      end
    end
    // ports 0 and 1 direction in byte halves
    if (idx == DIR0L_IDX) begin
      d = '{1'b1, 4'h0, K_DIR, LANE_L};
    end
    if (idx == DIR0H_IDX) begin
      d = '{1'b1, 4'h0, K_DIR, LANE_H};
    end
    if (idx == DIR1L_IDX) begin
      d = '{1'b1, 4'h1, K_DIR, LANE_L};
    end
    if (idx == DIR1H_IDX) begin
      d = '{1'b1, 4'h1, K_DIR, LANE_H};
    end
    if (idx == LV0_IDX) begin
      d = '{1'b1, 4'h0, K_LV0, LANE_W};
    end
    if (idx == LV1_IDX) begin
      d = '{1'b1, 4'h0, K_LV1, LANE_W};
    end
    return d;
  endfunction : decode

  function automatic logic [PW-1:0] merge(input logic [PW-1:0] old,
      input logic [PW-1:0] w, input lane_t lane);
    case (lane)
      LANE_L: merge = {old[15:8], w[7:0]};
      LANE_H: merge = {w[7:0], old[7:0]};
      default: merge = w;
    endcase
  endfunction : merge

  function automatic logic [PW-1:0] pick(input logic [PW-1:0] v,
      input lane_t lane);
    case (lane)
      LANE_L: pick = {8'h00, v[7:0]};
      LANE_H: pick = {8'h00, v[15:8]};
      default: pick = v;
    endcase
  endfunction : pick

  // state
  port_vec_t out_r, out_nxt;
  port_vec_t dir_r, dir_nxt;
  port_vec_t odt_r, odt_nxt;
  port_vec_t in_r, in_nxt;
  port_vec_t view;
  pad_ctrl_t pad_r, pad_nxt;
  level_sel_t lvl_r, lvl_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic tick;
  phase_t ph_r, ph_nxt;
  dec_t dec_r, dec_nxt, dec_a;
  logic [31:0] rd_r, rd_nxt;
  logic take;
  int wp;
  logic wr_hit;
  logic [PW-1:0] wr_word;
  logic [PW-1:0] port_view;
  wire port_vec_t smp_nxt;
  wire port_vec_t drv_nxt;
  wire port_vec_t en_nxt;

  // state-time divider
  always_comb begin
    tick = (cnt_r == CW'(STATE_CYC - 1));
    cnt_nxt = tick ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // input latch, every state time whatever the direction
  generate
    for (genvar g = 0; g < NPORT; g++) begin : g_smp
      assign smp_nxt[g] = tick ? (pin_i[g] & LINE_MASK[g]) : in_r[g];
    end
  endgenerate

  always_comb begin
    in_nxt = smp_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_r <= '0;
    end else begin
      in_r <= in_nxt;
    end
  end

  // read view: latch on outputs, sampled pin on inputs
  always_comb begin
    view = (dir_r & out_r) | (~dir_r & in_r);
  end

  // bus phase tracking
  always_comb begin
    take = hsel && hready && htrans[1];
    dec_a = decode(haddr[AW-1:2]);
    ph_nxt = ph_r;
    dec_nxt = dec_r;
    case (ph_r)
      PH_RD1: ph_nxt = PH_RD2;
      default: begin
        ph_nxt = PH_IDLE;
        if (take) begin
          ph_nxt = hwrite ? PH_WR : PH_RD1;
          dec_nxt = dec_a;
        end
      end
    endcase
    hreadyout = (ph_r != PH_RD1);
    hresp = 1'b0;
  end

  // bus phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= PH_IDLE;
      dec_r <= '0;
    end else begin
      ph_r <= ph_nxt;
      dec_r <= dec_nxt;
    end
  end

  // decoded port, data word and its read view
  always_comb begin
    wp = int'(dec_r.port);
    wr_hit = (ph_r == PH_WR) && dec_r.hit && (wp < NPORT);
    wr_word = hwdata[PW-1:0];
    port_view = '0;
    if (wp < NPORT) begin
      port_view = view[wp];
    end
  end

  // output latch: plain, set and clear writes
  always_comb begin
    out_nxt = out_r;
    if (wr_hit) begin
      case (dec_r.kind)
        K_DAT: out_nxt[wp] = wr_word & OUT_MASK[wp];
        K_SET: out_nxt[wp] = (port_view | wr_word) & OUT_MASK[wp];
        K_CLR: out_nxt[wp] = (port_view & ~wr_word) & OUT_MASK[wp];
        default: out_nxt = out_r;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // direction bits, ports 0 and 1 in byte halves
  always_comb begin
    dir_nxt = dir_r;
    if (wr_hit && dec_r.kind == K_DIR) begin
      dir_nxt[wp] = merge(dir_r[wp], wr_word, dec_r.lane) &
          OUT_MASK[wp];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r <= {NPORT{REG_RST}};
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // driver type bits
  always_comb begin
    odt_nxt = odt_r;
    if (wr_hit && dec_r.kind == K_ODT) begin
      odt_nxt[wp] = wr_word & ODT_MASK[wp];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      odt_r <= {NPORT{REG_RST}};
    end else begin
      odt_r <= odt_nxt;
    end
  end

  // input threshold selects
  always_comb begin
    lvl_nxt = lvl_r;
    if (wr_hit && dec_r.kind == K_LV0) begin
      lvl_nxt.std_sel = wr_word;
    end
    if (wr_hit && dec_r.kind == K_LV1) begin
      lvl_nxt.ext_sel = wr_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_r <= '0;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  // read data, captured in the wait cycle
  always_comb begin
    rd_nxt = rd_r;
    if (ph_r == PH_RD1) begin
      rd_nxt = '0;
      if (dec_r.hit && wp < NPORT) begin
        case (dec_r.kind)
          K_DAT, K_SET, K_CLR: rd_nxt = {16'h0000, port_view};
          K_DIR: rd_nxt = {16'h0000, pick(dir_r[wp], dec_r.lane)};
          K_ODT: rd_nxt = {16'h0000, odt_r[wp]};
          K_LV0: rd_nxt = {16'h0000, lvl_r.std_sel};
          K_LV1: rd_nxt = {16'h0000, lvl_r.ext_sel};
          default: rd_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // pad drive per port: push-pull or low-only open drain, hi-z on inputs
  generate
    for (genvar g = 0; g < NPORT; g++) begin : g_pad
      assign drv_nxt[g] = out_r[g] & ~odt_r[g] & OUT_MASK[g];
      assign en_nxt[g] = dir_r[g] & OUT_MASK[g] &
          (~odt_r[g] | ~out_r[g]);
    end
  endgenerate

  always_comb begin
    pad_nxt.drive = drv_nxt;
    pad_nxt.enable = en_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_r <= '0;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  assign hrdata = rd_r;
  assign pad_o = pad_r;
  assign level_o = lvl_r;
endmodule : parallel_io_port_group
`default_nettype wire

//--- rtl/gpio_pkg.sv
// shared constants, register indices and carrier types for the port group
`default_nettype none
package gpio_pkg;
  localparam int NPORT = 9;
  localparam int PW = 16;
  localparam int IDXW = 16;
  localparam int AW = IDXW + 2;
  localparam int STATE_TIME_CYC = 2;

  typedef logic [NPORT-1:0][PW-1:0] port_vec_t;

  typedef struct packed {
    port_vec_t drive;
    port_vec_t enable;
  } pad_ctrl_t;

  typedef struct packed {
    logic [PW-1:0] std_sel;
    logic [PW-1:0] ext_sel;
  } level_sel_t;

  typedef enum logic [2:0] {
    K_DAT = 3'b000,
    K_DIR = 3'b001,
    K_ODT = 3'b010,
    K_SET = 3'b011,
    K_CLR = 3'b100,
    K_LV0 = 3'b101,
    K_LV1 = 3'b110
  } kind_t;

  typedef enum logic [1:0] {
    LANE_W = 2'b00,
    LANE_L = 2'b01,
    LANE_H = 2'b10
  } lane_t;

  typedef struct packed {
    logic hit;
    logic [3:0] port;
    kind_t kind;
    lane_t lane;
  } dec_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WR = 2'b01,
    PH_RD1 = 2'b10,
    PH_RD2 = 2'b11
  } phase_t;

  // lines present per port; port 3 line 14 absent
  localparam port_vec_t LINE_MASK = {
    16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF,
    16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  // port 5 has no output latch or driver
  localparam port_vec_t OUT_MASK = {
    16'h00FF, 16'h00FF, 16'h00FF, 16'h0000, 16'h00FF,
    16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  // driver type selectable only on ports 2,3,4,6,7,8
  localparam port_vec_t ODT_MASK = {
    16'h00FF, 16'h00FF, 16'h00FF, 16'h0000, 16'h00FF,
    16'hBFFF, 16'hFFFF, 16'h0000, 16'h0000};

  typedef logic [NPORT-1:0][IDXW-1:0] idx_vec_t;
  localparam idx_vec_t DIR_IDX = {
    16'hFFD6, 16'hFFD2, 16'hFFCE, 16'h0000, 16'hFFCA,
    16'hFFC6, 16'hFFC2, 16'h0000, 16'h0000};
  localparam idx_vec_t ODT_IDX = {
    16'hF1D6, 16'hF1D2, 16'hF1CE, 16'h0000, 16'hF1CA,
    16'hF1C6, 16'hF1C2, 16'h0000, 16'h0000};
  localparam logic [IDXW-1:0] DIR0L_IDX = 16'hF100;
  localparam logic [IDXW-1:0] DIR0H_IDX = 16'hF102;
  localparam logic [IDXW-1:0] DIR1L_IDX = 16'hF104;
  localparam logic [IDXW-1:0] DIR1H_IDX = 16'hF106;
  localparam logic [IDXW-1:0] DAT_BASE = 16'hE000;
  localparam logic [IDXW-1:0] SET_BASE = 16'hE020;
  localparam logic [IDXW-1:0] CLR_BASE = 16'hE040;
  localparam logic [IDXW-1:0] LV0_IDX = 16'hF1F0;
  localparam logic [IDXW-1:0] LV1_IDX = 16'hF1F2;
  localparam logic [IDXW-1:0] STRIDE = 16'h0002;
  localparam logic [PW-1:0] REG_RST = 16'h0000;
endpackage : gpio_pkg
`default_nettype wire

//--- bench/gpio_assertions.sv
// bus timing and pad output checks for the port group
`default_nettype none
module gpio_assertions (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // pads
  input wire gpio_pkg::pad_ctrl_t pad_o,
  input wire gpio_pkg::level_sel_t level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_pkg::*;
  logic wr_dp_r;
  logic wr_dp_nxt;
  always_comb begin
    wr_dp_nxt = hready ? (hsel && htrans[1] && hwrite) : wr_dp_r;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_r <= 1'b0;
    end else begin
      wr_dp_r <= wr_dp_nxt;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take(logic w);
    hsel && hready && htrans[1] && hwrite == w;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (s_take(1'b0) |=> s_rd_answer)
    else $error("read wait state wrong");
  a_write_nowait: assert property (s_take(1'b1) |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_port5_idle: assert property (pad_o.enable[5] == 16'h0000)
    else $error("input-only port driven");
  a_absent_lines: assert property ((pad_o.enable & ~OUT_MASK) == '0)
    else $error("absent line driven");
  a_reset_hiz: assert property ($rose(hresetn) |-> pad_o.enable == '0)
    else $error("pad driven after reset");
  a_pad_after_write: assert property (!$stable(pad_o) |-> $past(wr_dp_r, 2))
    else $error("pad changed without write");
  a_level_after_write: assert property (!$stable(level_o) |->
    $past(wr_dp_r, 1) || $past(wr_dp_r, 2))
    else $error("level select changed without write");
endmodule : gpio_assertions
bind parallel_io_port_group gpio_assertions chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .pad_o(pad_o),
  .level_o(level_o));
`default_nettype wire

//--- bench/pin_model.sv
// external circuitry: pads show the outside level where not driven
`default_nettype none
module pin_model (
  // pad controls and outside levels
  input wire gpio_pkg::pad_ctrl_t pad_o,
  input wire gpio_pkg::port_vec_t ext_i,
  // sensed levels
  output gpio_pkg::port_vec_t pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_pkg::*;
  assign pin_o = (pad_o.enable & pad_o.drive) | (~pad_o.enable & ext_i);
endmodule : pin_model
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the parallel port group
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_pkg::*;
  localparam logic [15:0] P2D = DAT_BASE + 16'h0004;
  localparam logic [15:0] P5D = DAT_BASE + 16'h000A;
  localparam logic [3:0][15:0] BH = {DIR1H_IDX, DIR1L_IDX, DIR0H_IDX,
    DIR0L_IDX};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [AW-1:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, q;
  port_vec_t pin_i;
  port_vec_t ext = '0;
  pad_ctrl_t pad_o;
  level_sel_t level_o;
  int fails = 0;
  int n_checks = 0;
  always #5 hclk = ~hclk;
  parallel_io_port_group #(.STATE_CYC(2)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_i(pin_i), .pad_o(pad_o), .level_o(level_o));
  pin_model pins (.pad_o(pad_o), .ext_i(ext), .pin_o(pin_i));
  task automatic bus(input logic w, input logic [15:0] i,
    input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {i, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic rd_chk(input logic [15:0] i, input logic [15:0] e);
    bus(1'b0, i, 16'h0000);
    cmp(q[15:0], e);
  endtask : rd_chk
  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int p = 2; p < NPORT; p++) begin
      if (p != 5) begin
        rd_chk(DIR_IDX[p], 16'h0000);
        rd_chk(ODT_IDX[p], 16'h0000);
      end
    end
    for (int i = 0; i < 4; i++) begin
      rd_chk(BH[i], 16'h0000);
      bus(1'b1, BH[i], 16'hFFFF);
      rd_chk(BH[i], 16'h00FF);
    end
    bus(1'b1, DIR_IDX[3], 16'hFFFF);
    rd_chk(DIR_IDX[3], 16'hBFFF);
    bus(1'b1, ODT_IDX[4], 16'hFFFF);
    rd_chk(ODT_IDX[4], 16'h00FF);
    ext[2] <= 16'hA5C3;
    ext[5] <= 16'h3C3C;
    bus(1'b1, P2D, 16'h1234);
    repeat (8) @(posedge hclk);
    rd_chk(P2D, 16'hA5C3);
    cmp(pad_o.enable[2], 16'h0000);
    bus(1'b1, SET_BASE + 16'h0004, 16'h0004);
    bus(1'b1, DIR_IDX[2], 16'hFFFF);
    repeat (4) @(posedge hclk);
    rd_chk(P2D, 16'hA5C7);
    cmp(pad_o.drive[2], 16'hA5C7);
    cmp(pad_o.enable[2], 16'hFFFF);
    bus(1'b1, CLR_BASE + 16'h0004, 16'h0080);
    repeat (4) @(posedge hclk);
    rd_chk(P2D, 16'hA547);
    cmp(pad_o.drive[2], 16'hA547);
    bus(1'b1, ODT_IDX[2], 16'hFFFF);
    repeat (4) @(posedge hclk);
    cmp(pad_o.drive[2], 16'h0000);
    cmp(pad_o.enable[2], 16'h5AB8);
    bus(1'b1, SET_BASE + 16'h0004, 16'h0000);
    rd_chk(P2D, 16'hA547);
    bus(1'b1, P5D, 16'hFFFF);
    rd_chk(P5D, 16'h3C3C);
    cmp(pad_o.enable[5], 16'h0000);
    bus(1'b1, LV0_IDX, 16'h1234);
    bus(1'b1, LV1_IDX, 16'hBEEF);
    repeat (4) @(posedge hclk);
    cmp(level_o.std_sel, 16'h1234);
    cmp(level_o.ext_sel, 16'hBEEF);
    bus(1'b1, 16'h0100, 16'hFFFF);
    rd_chk(16'h0100, 16'h0000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(DIR_IDX[2], 16'h0000);
    rd_chk(ODT_IDX[2], 16'h0000);
    cmp(pad_o.enable[2], 16'h0000);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
